/* File: logic/scb_pkg.sv */
// Constants shared by the sample capture buffer modules.
// Assumes a single 125 MHz core clock domain.
package scb_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 10;
    localparam int PTR_W = 11;
    localparam int DEPTH = 1024;
    localparam int PIN_W = 24;
    localparam int PER_W = 12;
    // Capacity per buffer size select code
    localparam logic [10:0] CAP_SEL0 = 11'h080;
    localparam logic [10:0] CAP_SEL1 = 11'h100;
    localparam logic [10:0] CAP_SEL2 = 11'h200;
    localparam logic [10:0] CAP_SEL3 = 11'h400;
    localparam logic [10:0] PTR_RST = 11'h000;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [11:0] PER_MAX = 12'hfff;
    localparam logic [11:0] PER_ONE = 12'h001;
    localparam logic [11:0] PER_RST = 12'h000;
    localparam logic [2:0] SHIFT_BASE = 3'h1;
endpackage

/* File: logic/scb_clk_if.sv */
// Sample clock handshake between capture core and clock multiplier.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface scb_clk_if;
    logic ref_rise;
    logic mult_en;
    logic [1:0] factor;
    logic sample_tick;
    modport gen (input ref_rise, input mult_en, input factor, output sample_tick);
    modport core (output ref_rise, output mult_en, output factor, input sample_tick);
endinterface

/* File: logic/scb_sync.sv */
// Two-flop synchronisers for pins entering the core clock domain.
// Assumes each bit is independent; buses are only sampled when steady.
`timescale 1ns/1ps
module scb_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Pins
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            logic meta_r;
            logic stab_r;
            always_ff @(posedge i_clk)
            begin
                if (!i_rst_n)
                begin
                    meta_r <= 1'b0;
                    stab_r <= 1'b0;
                end
                else
                begin
                    meta_r <= i_async[g];
                    stab_r <= meta_r;
                end
            end
            assign o_sync[g] = stab_r;
        end
    endgenerate
endmodule

/* File: logic/scb_mult.sv */
// Sample tick generator: pin clock edges in bypass, multiplied ticks otherwise.
// Assumes reference edges arrive as one-cycle pulses on the core clock.
`timescale 1ns/1ps
module scb_mult (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Tick port
    scb_clk_if.gen clk_if
);
    logic [11:0] per_r;
    logic [11:0] per_nxt;
    logic [11:0] step_r;
    logic [11:0] step_nxt;
    logic [11:0] ph_r;
    logic [11:0] ph_nxt;
    logic [11:0] div;
    logic [2:0] shift;
    logic tick;

    always_comb
    begin
        shift = {1'b0, clk_if.factor} + scb_pkg::SHIFT_BASE;
        div = per_r >> shift;
        // Multiplied tick; period follows the last measured reference period
        tick = clk_if.ref_rise | (clk_if.mult_en & (ph_r >= step_r));
        if (!clk_if.mult_en)
        begin
            tick = clk_if.ref_rise;
        end
        per_nxt = clk_if.ref_rise ? scb_pkg::PER_ONE :
            (per_r == scb_pkg::PER_MAX ? per_r : per_r + scb_pkg::PER_ONE);
        step_nxt = step_r;
        if (clk_if.ref_rise)
        begin
            // Never below one cycle, so a too fast reference cannot stall ticks
            step_nxt = (div == scb_pkg::PER_RST) ? scb_pkg::PER_ONE : div;
        end
        ph_nxt = tick ? scb_pkg::PER_ONE :
            (ph_r == scb_pkg::PER_MAX ? ph_r : ph_r + scb_pkg::PER_ONE);
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            per_r <= scb_pkg::PER_RST;
            step_r <= scb_pkg::PER_MAX;
            ph_r <= scb_pkg::PER_RST;
        end
        else
        begin
            per_r <= per_nxt;
            step_r <= step_nxt;
            ph_r <= ph_nxt;
        end
    end

    assign clk_if.sample_tick = tick;
endmodule

/* File: logic/scb_top.sv */
// Sample capture buffer control: storage, read-out, flags, sleep and strobe.
// Assumes all pins but I_RESETN are asynchronous to I_MCLK and are synchronised here;
// pin clocks must stay well below half of I_MCLK to be seen edge by edge.
`timescale 1ns/1ps
module scb_top (
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RESETN,
    input wire logic I_DEV_RESET,
    // Clocking pins
    input wire logic I_SAMPLE_CLK_PIN,
    input wire logic I_MULT_ENABLE,
    input wire logic [1:0] I_MULT_FACTOR,
    input wire logic I_READ_CLK_PIN,
    // Buffer control pins
    input wire logic I_WRITE_ENABLE,
    input wire logic I_READ_ENABLE,
    input wire logic I_BUFFER_ENABLE,
    input wire logic I_AUTO_STOP_WRITE,
    input wire logic [1:0] I_BUFFER_SIZE_SELECT,
    // Power and output control pins
    input wire logic I_CHIP_SLEEP,
    input wire logic I_CONVERTER_SLEEP,
    input wire logic I_OUTPUT_ENABLE,
    input wire logic I_OUTPUT_EDGE_SELECT,
    // Converter samples
    input wire logic [7:0] I_CONV_DATA,
    // Data pins
    output logic [7:0] O_SAMPLE_DATA_OUT,
    output logic O_SAMPLE_DATA_OE,
    output logic O_DATA_READY_STROBE,
    // Status pins
    output logic O_WRITE_ENABLE_SYNCED,
    output logic O_FULL_FLAG,
    output logic O_EMPTY_FLAG,
    output logic O_CONVERTER_ACTIVE
);
    logic [scb_pkg::PIN_W-1:0] pin_raw;
    logic [scb_pkg::PIN_W-1:0] pin_s;
    logic sclk_s;
    logic rclk_s;
    logic wen_s;
    logic ren_s;
    logic asw_s;
    logic slp_s;
    logic cslp_s;
    logic oe_s;
    logic edge_s;
    logic drst_s;
    logic ben_s;
    logic men_s;
    logic [1:0] fac_s;
    logic [1:0] bsz_s;
    logic [7:0] conv_s;

    logic [7:0] mem_r [0:scb_pkg::DEPTH-1];
    logic [10:0] wr_ptr_r;
    logic [10:0] wr_ptr_nxt;
    logic [10:0] rd_ptr_r;
    logic [10:0] rd_ptr_nxt;
    logic [7:0] dout_r;
    logic [7:0] dout_nxt;
    logic sclk_d_r;
    logic rclk_d_r;
    logic wsync_r;
    logic wsync_nxt;
    logic stop_r;
    logic stop_nxt;
    logic full_r;
    logic full_nxt;
    logic empty_r;
    logic empty_nxt;
    logic data_ready_strobe_r;
    logic data_ready_strobe_nxt;

    logic clr;
    logic sclk_rise;
    logic rclk_rise;
    logic tick;
    logic [10:0] count;
    logic [10:0] count_nxt;
    logic [10:0] cap;
    logic full_now;
    logic empty_now;
    logic do_wr;
    logic do_rd;
    logic bypass_upd;
    logic upd;

    function automatic logic [10:0] cap_of(input logic [1:0] sel);
        logic [10:0] c;
        c = scb_pkg::CAP_SEL3;
        unique case (sel)
            2'h0: c = scb_pkg::CAP_SEL0;
            2'h1: c = scb_pkg::CAP_SEL1;
            2'h2: c = scb_pkg::CAP_SEL2;
            2'h3: c = scb_pkg::CAP_SEL3;
        endcase
        return c;
    endfunction

    assign pin_raw = {I_SAMPLE_CLK_PIN, I_READ_CLK_PIN, I_WRITE_ENABLE, I_READ_ENABLE,
        I_AUTO_STOP_WRITE, I_CHIP_SLEEP, I_CONVERTER_SLEEP, I_OUTPUT_ENABLE,
        I_OUTPUT_EDGE_SELECT, I_DEV_RESET, I_BUFFER_ENABLE, I_MULT_ENABLE,
        I_MULT_FACTOR, I_BUFFER_SIZE_SELECT, I_CONV_DATA};
    assign {sclk_s, rclk_s, wen_s, ren_s, asw_s, slp_s, cslp_s, oe_s, edge_s, drst_s,
        ben_s, men_s, fac_s, bsz_s, conv_s} = pin_s;

    scb_sync #(.W(scb_pkg::PIN_W)) u_sync (
        .i_clk(I_MCLK),
        .i_rst_n(I_RESETN),
        .i_async(pin_raw),
        .o_sync(pin_s)
    );

    scb_clk_if clk_if ();

    assign clk_if.ref_rise = sclk_rise;
    assign clk_if.mult_en = men_s;
    assign clk_if.factor = fac_s;
    assign tick = clk_if.sample_tick;

    scb_mult u_mult (
        .i_clk(I_MCLK),
        .i_rst_n(I_RESETN),
        .clk_if(clk_if.gen)
    );

    always_comb
    begin
        clr = drst_s | slp_s;
        sclk_rise = sclk_s & ~sclk_d_r;
        rclk_rise = rclk_s & ~rclk_d_r;
        count = wr_ptr_r - rd_ptr_r;
        cap = cap_of(bsz_s);
        full_now = count >= cap;
        empty_now = count == scb_pkg::PTR_RST;
        wsync_nxt = tick ? wen_s : wsync_r;
        // Converter sleep blocks capture and bypass updates; reads go on
        do_wr = tick & wen_s & ben_s & ~cslp_s & ~clr & ~full_now & ~stop_r;
        do_rd = rclk_rise & ren_s & ben_s & ~empty_now & ~clr;
        // Buffer disabled: converter words go straight to the pins
        bypass_upd = ~ben_s & tick & ~cslp_s & ~clr;
        upd = do_rd | bypass_upd;
        stop_nxt = stop_r;
        if (clr | ~wen_s)
        begin
            stop_nxt = 1'b0;
        end
        else if (ben_s & asw_s & full_now)
        begin
            stop_nxt = 1'b1;
        end
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        if (clr)
        begin
            wr_ptr_nxt = scb_pkg::PTR_RST;
            rd_ptr_nxt = scb_pkg::PTR_RST;
        end
        else
        begin
            if (do_wr)
            begin
                wr_ptr_nxt = wr_ptr_r + 11'h001;
            end
            if (do_rd)
            begin
                rd_ptr_nxt = rd_ptr_r + 11'h001;
            end
        end
        count_nxt = wr_ptr_nxt - rd_ptr_nxt;
        full_nxt = count_nxt >= cap;
        empty_nxt = empty_r;
        if (clr)
        begin
            empty_nxt = 1'b1;
        end
        else if (rclk_rise)
        begin
            empty_nxt = count_nxt == scb_pkg::PTR_RST;
        end
        dout_nxt = dout_r;
        if (do_rd)
        begin
            dout_nxt = mem_r[rd_ptr_r[scb_pkg::ADDR_W-1:0]];
        end
        else if (bypass_upd)
        begin
            dout_nxt = conv_s;
        end
        // Strobe edge lands with the data; idle level is the opposite one
        data_ready_strobe_nxt = upd ? edge_s : ~edge_s;
    end

    always_ff @(posedge I_MCLK)
    begin
        if (!I_RESETN)
        begin
            wr_ptr_r <= scb_pkg::PTR_RST;
            rd_ptr_r <= scb_pkg::PTR_RST;
            dout_r <= scb_pkg::DATA_RST;
            sclk_d_r <= 1'b0;
            rclk_d_r <= 1'b0;
            wsync_r <= 1'b0;
            stop_r <= 1'b0;
            full_r <= 1'b0;
            empty_r <= 1'b1;
            data_ready_strobe_r <= 1'b0;
        end
        else
        begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            dout_r <= dout_nxt;
            sclk_d_r <= sclk_s;
            rclk_d_r <= rclk_s;
            wsync_r <= wsync_nxt;
            stop_r <= stop_nxt;
            full_r <= full_nxt;
            empty_r <= empty_nxt;
            data_ready_strobe_r <= data_ready_strobe_nxt;
        end
    end

    // Storage has no reset; pointers alone define what is valid
    always_ff @(posedge I_MCLK)
    begin
        if (do_wr)
        begin
            mem_r[wr_ptr_r[scb_pkg::ADDR_W-1:0]] <= conv_s;
        end
    end

    assign O_SAMPLE_DATA_OUT = dout_r;
    assign O_SAMPLE_DATA_OE = oe_s;
    assign O_DATA_READY_STROBE = data_ready_strobe_r;
    assign O_WRITE_ENABLE_SYNCED = wsync_r;
    assign O_FULL_FLAG = full_r;
    assign O_EMPTY_FLAG = empty_r;
    assign O_CONVERTER_ACTIVE = ~(slp_s | cslp_s);

    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (!I_RESETN);

    a_depth_bound: assert property (count <= scb_pkg::CAP_SEL3)
        else $error("buffer count above depth");
    a_full_exact: assert property ($stable(bsz_s) |-> O_FULL_FLAG == ($past(count_nxt) >= cap))
        else $error("full flag does not match fill level");
    a_no_overwrite: assert property (full_now |-> !do_wr)
        else $error("write accepted while full");
    a_empty_hold: assert property ((rclk_rise && empty_now && !do_wr) |=> $stable(rd_ptr_r))
        else $error("read pointer moved while empty");
    a_sleep_clear: assert property (slp_s |=> (count == scb_pkg::PTR_RST) && !O_FULL_FLAG)
        else $error("chip sleep did not clear buffer");
    a_sleep_hold: assert property ((slp_s && $past(slp_s)) |-> $stable(O_SAMPLE_DATA_OUT))
        else $error("data changed during chip sleep");
    a_write_step: assert property (do_wr |=> wr_ptr_r == $past(wr_ptr_r) + 11'h001)
        else $error("write did not advance pointer");
    a_read_step: assert property (do_rd |=> rd_ptr_r == $past(rd_ptr_r) + 11'h001 ##1 !do_rd)
        else $error("read did not advance pointer");
    a_strobe_edge: assert property (upd |=> O_DATA_READY_STROBE == $past(edge_s))
        else $error("strobe level wrong at data change");
    a_empty_timing: assert property ($changed(O_EMPTY_FLAG) |-> $past(rclk_rise) || $past(clr))
        else $error("empty flag moved off read clock edge");
    a_auto_stop: assert property ((stop_r && wen_s) |-> !do_wr ##1 stop_r || !wen_s || clr)
        else $error("write after auto stop");
    a_conv_sleep: assert property ((cslp_s && rclk_rise && ren_s && ben_s && !empty_now && !clr)
        |=> rd_ptr_r == $past(rd_ptr_r) + 11'h001)
        else $error("read blocked during converter sleep");
endmodule

/* File: tb/scb_reader.sv */
// Reader model: drives read clock and read enable pins, returns bytes.
// Assumes pin clocks are seen by the block about three core cycles late.
`timescale 1ns/1ps
module scb_reader (
    // Core clock
    input wire logic i_clk,
    // Data pins
    input wire logic [7:0] i_data,
    // Read pins
    output logic o_rclk,
    output logic o_ren
);
    initial
    begin
        o_rclk = 1'b0;
        o_ren = 1'b0;
    end
    // One read clock period; enable set while the clock is low
    task automatic pulse(input logic ren, output logic [7:0] d);
        @(negedge i_clk);
        o_ren = ren;
        repeat (2) @(negedge i_clk);
        o_rclk = 1'b1;
        repeat (5) @(negedge i_clk);
        o_rclk = 1'b0;
        d = i_data;
        repeat (3) @(negedge i_clk);
        o_ren = 1'b0;
    endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the sample capture buffer top.
// Assumes the reader model owns the read clock and read enable pins.
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic dres = 1'b0;
    logic spin = 1'b0;
    logic men = 1'b0;
    logic [1:0] mfac = 2'h0;
    logic we = 1'b0;
    logic ben = 1'b1;
    logic auto_stop_write = 1'b0;
    logic [1:0] bsel = 2'h0;
    logic csl = 1'b0;
    logic vsl = 1'b0;
    logic oe = 1'b0;
    logic esel = 1'b1;
    logic [7:0] conv = 8'h00;
    logic rclk, ren, soe, strb, wsy, full, empty, cact;
    logic [7:0] dout, rd;
    logic [7:0] pd = 8'h00;
    logic ps = 1'b0;
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    always #4 clk = ~clk;
    scb_top dut (
        .I_MCLK(clk),
        .I_RESETN(rstn),
        .I_DEV_RESET(dres),
        .I_SAMPLE_CLK_PIN(spin),
        .I_MULT_ENABLE(men),
        .I_MULT_FACTOR(mfac),
        .I_READ_CLK_PIN(rclk),
        .I_WRITE_ENABLE(we),
        .I_READ_ENABLE(ren),
        .I_BUFFER_ENABLE(ben),
        .I_AUTO_STOP_WRITE(auto_stop_write),
        .I_BUFFER_SIZE_SELECT(bsel),
        .I_CHIP_SLEEP(csl),
        .I_CONVERTER_SLEEP(vsl),
        .I_OUTPUT_ENABLE(oe),
        .I_OUTPUT_EDGE_SELECT(esel),
        .I_CONV_DATA(conv),
        .O_SAMPLE_DATA_OUT(dout),
        .O_SAMPLE_DATA_OE(soe),
        .O_DATA_READY_STROBE(strb),
        .O_WRITE_ENABLE_SYNCED(wsy),
        .O_FULL_FLAG(full),
        .O_EMPTY_FLAG(empty),
        .O_CONVERTER_ACTIVE(cact)
    );
    scb_reader rdr (
        .i_clk(clk),
        .i_data(dout),
        .o_rclk(rclk),
        .o_ren(ren)
    );
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("Counts: %0d checks, %0d mismatches", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Data settles two cycles before the pin clock rises
    task automatic sclk(input logic [7:0] d);
        conv = d;
        wt(2);
        spin = 1'b1;
        wt(4);
        spin = 1'b0;
        wt(2);
    endtask
    task automatic clr;
        dres = 1'b1;
        wt(5);
        dres = 1'b0;
        wt(4);
        chk("empty after clear", empty, 1'b1);
        chk("full after clear", full, 1'b0);
    endtask
    // Data edges must meet the strobe entering the edge select level
    always @(negedge clk)
    begin
        if (rstn && dout !== pd)
            chk("strobe at data edge", {ps, strb}, {~esel, esel});
        pd = dout;
        ps = strb;
    end
    always @(negedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            fails++;
            complete_run();
        end
    end
    task automatic t_reset;
        chk("data", dout, 8'h00);
        chk("strobe", strb, 1'b0);
        chk("full", full, 1'b0);
        chk("empty", empty, 1'b1);
        chk("wen synced", wsy, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_oe;
        oe = 1'b1;
        wt(4);
        chk("oe high", soe, 1'b1);
        oe = 1'b0;
        wt(4);
        chk("oe low", soe, 1'b0);
        $display("test oe done");
    endtask
    task automatic t_sizes;
        int cap;
        for (int c = 0; c < 4; c++)
        begin
            bsel = 2'(c);
            cap = 128 << c;
            auto_stop_write = c[0];
            we = 1'b1;
            repeat (cap - 1) sclk(8'h55);
            wt(4);
            chk("full below cap", full, 1'b0);
            sclk(8'h55);
            wt(4);
            chk("full at cap", full, 1'b1);
            chk("wen synced", wsy, 1'b1);
            we = 1'b0;
            clr();
        end
        $display("test sizes done");
    endtask
    task automatic t_fill;
        bsel = 2'h0;
        auto_stop_write = 1'b1;
        we = 1'b1;
        for (int i = 0; i < 130; i++)
            sclk(8'(i));
        we = 1'b0;
        wt(4);
        chk("full", full, 1'b1);
        rdr.pulse(1'b0, rd);
        chk("empty after writes", empty, 1'b0);
        for (int i = 0; i < 128; i++)
        begin
            esel = i[5];
            rdr.pulse(1'b1, rd);
            chk("read byte", rd, 8'(i));
            if (i == 0)
                chk("full after read", full, 1'b0);
        end
        chk("empty drained", empty, 1'b1);
        rdr.pulse(1'b1, rd);
        chk("read when empty", rd, 8'h7f);
        $display("test fill done");
    endtask
    task automatic t_sleep;
        we = 1'b1;
        for (int i = 0; i < 4; i++)
            sclk(8'(160 + i));
        vsl = 1'b1;
        wt(4);
        chk("converter active", cact, 1'b0);
        sclk(8'hee);
        sclk(8'hee);
        we = 1'b0;
        rdr.pulse(1'b0, rd);
        for (int i = 0; i < 4; i++)
        begin
            rdr.pulse(1'b1, rd);
            chk("read in sleep", rd, 8'(160 + i));
        end
        chk("no capture in sleep", empty, 1'b1);
        vsl = 1'b0;
        wt(4);
        chk("converter awake", cact, 1'b1);
        $display("test sleep done");
    endtask
    task automatic t_chip;
        we = 1'b1;
        sclk(8'hb0);
        sclk(8'hb1);
        sclk(8'hb2);
        we = 1'b0;
        rdr.pulse(1'b0, rd);
        rdr.pulse(1'b1, rd);
        chk("first byte", rd, 8'hb0);
        csl = 1'b1;
        wt(6);
        chk("empty in sleep", empty, 1'b1);
        chk("full in sleep", full, 1'b0);
        chk("held byte", dout, 8'hb0);
        chk("converter off in chip sleep", cact, 1'b0);
        csl = 1'b0;
        wt(4);
        rdr.pulse(1'b1, rd);
        chk("contents lost", rd, 8'hb0);
        $display("test chip sleep done");
    endtask
    // Buffer disabled: converter word goes straight out, nothing is stored
    task automatic t_bypass;
        ben = 1'b0;
        we = 1'b1;
        sclk(8'h3c);
        we = 1'b0;
        wt(4);
        chk("bypass data", dout, 8'h3c);
        ben = 1'b1;
        rdr.pulse(1'b0, rd);
        chk("no store when disabled", empty, 1'b1);
        $display("test bypass done");
    endtask
    // 100 edges at x2 and 50 edges at x4 both fill 128 bytes; x2 alone cannot at 50
    task automatic t_mult;
        men = 1'b1;
        bsel = 2'h0;
        auto_stop_write = 1'b0;
        for (int f = 0; f < 2; f++)
        begin
            mfac = 2'(f);
            we = 1'b1;
            repeat (100 >> f)
            begin
                spin = 1'b1;
                wt(8);
                spin = 1'b0;
                wt(8);
            end
            chk("full with multiplier", full, 1'b1);
            we = 1'b0;
            clr();
        end
        men = 1'b0;
        $display("test multiplier done");
    endtask
    initial
    begin
        wt(4);
        rstn = 1'b1;
        // Strobe idle level follows the synced edge select, settled by the fourth edge
        wt(4);
        t_reset();
        t_oe();
        t_sizes();
        t_fill();
        t_sleep();
        t_chip();
        t_bypass();
        t_mult();
        complete_run();
    end
endmodule
